// ==== rtc_calendar_defs.vh ====
// Constants for the calendar-mode real-time clock core.
// Assumes inclusion by bare name from the core and prescaler files.
`ifndef RTC_CALENDAR_DEFS_VH
`define RTC_CALENDAR_DEFS_VH

// ----------------------------------------------------------------
// Clock packing: sec[5:0] min[11:6] hour[16:12] day[21:17] mon[25:22] yr[31:26]
// ----------------------------------------------------------------
`define SEC_LSB 0
`define MIN_LSB 6
`define HOUR_LSB 12
`define DAY_LSB 17
`define MON_LSB 22
`define YEAR_LSB 26
`define PM_BIT 4

// ----------------------------------------------------------------
// Flag bit positions: [0] rollover, [1] compare, [2] alarm, [10:3] periods
// ----------------------------------------------------------------
`define FLAG_OVF 0
`define FLAG_CMP 1
`define FLAG_ALARM 2
`define FLAG_PER_LSB 3
`define FLAG_WIDTH 11

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define CLOCK_RESET 32'h00420000
`define YEAR_TOP 6'h3F
`define MONTH_DEC 4'hC
`define DAY_FIRST 5'h01
`define MONTH_FIRST 4'h1
`define DIV_OFF 4'h0
`define DIV_MAX 4'hA

`endif

// ==== rtc_prescaler.v ====
// Prescaler producing the counter clock tick and period ticks.
// Assumes the source clock tick arrives as a one-cycle enable pulse.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_calendar_defs.vh"

module rtc_prescaler (
  // Clock and reset
  input wire CORE_CLK,
  input wire RESET_N,
  // Control
  input wire [3:0] DIV_SEL,
  input wire SRC_TICK,
  // Ticks
  output reg CNT_TICK,
  output reg [7:0] PER_TICK
);

  reg [8:0] div_reg;
  wire [8:0] div_next = div_reg + 9'h001;
  wire [8:0] div_mask;

  // Divide by two to the power of (select - 1) for select 2 to 10; off, 1 and above 10 divide by one
  assign div_mask = (DIV_SEL <= `DIV_MAX && DIV_SEL > 4'h1) ?
                    ((9'h001 << (DIV_SEL - 4'h1)) - 9'h001) : 9'h000;

  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_reg <= 9'h000;
      CNT_TICK <= 1'b0;
      PER_TICK <= 8'h00;
    end else begin
      CNT_TICK <= SRC_TICK && ((div_reg & div_mask) == div_mask);
      if (SRC_TICK) begin
        div_reg <= div_next;
      end
      // Rising edge of each upper prescaler bit; nothing when off
      PER_TICK <= (SRC_TICK && DIV_SEL != `DIV_OFF) ?
                  (~div_reg[8:1] & div_next[8:1]) : 8'h00;
    end
  end

endmodule
`default_nettype wire

// ==== rtc_calendar_core.v ====
// Calendar-mode real-time clock core with alarm, compare and flag logic.
// Assumes software drives the control ports and pulses the write strobes.
//
// What this block does
// - Hours count in 12-hour or 24-hour form per the format select.
// - Format select only loads while the block is disabled.
// - Day of month starts at 1.
// - Month numbering starts at 1 for January through 12.
// - Year offset spans 0x00 to 0x3F from a leap reference year.
// - After year 0x3F Dec 31 23:59:59 wrap to year 0 Jan 1 00:00:00.
// - The full calendar wrap sets the rollover flag.
// - Current clock is compared against the 32-bit alarm value each count.
// - Alarm flag sets on the next counter clock tick after a match.
// - Mask select chooses which fields take part in the alarm match.
// - Clear-on-match resets the clock on the counter cycle after a match.
// - With clear-on-match, alarm and rollover flags set together.
// - Period flags set when their prescaler bit rises from 0 to 1.
// - Compare flag sets on the next counter clock tick after the counter equals the compare value.
// - Every source has its own flag set by its condition.
// - Enable-set writes of 1 enable, enable-clear writes of 1 disable.
// - Request is high while a flag is set and enabled.
// - Request holds until flag cleared, enable removed or reset.
// - All enabled requests are ORed onto one output.
// - Divider select: off and 1 divide by 1, up to 512.
// - Divider off gives no period events or flags.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_calendar_defs.vh"

module rtc_calendar_core #(
  parameter FLAGS = `FLAG_WIDTH
) (
  // Clock and reset
  input wire CORE_CLK,
  input wire RESET_N,
  // Control
  input wire ENABLE,
  input wire HOUR_FORMAT_SELECT,
  input wire CLEAR_ON_ALARM_MATCH,
  input wire [3:0] DIV_SEL,
  input wire RTC_SOURCE_CLOCK_TICK,
  // Alarm and compare
  input wire [31:0] ALARM_COMPARE_VALUE,
  input wire [2:0] ALARM_MASK_SELECT,
  input wire [31:0] COMPARE_VALUE,
  // Clock load
  input wire CLOCK_WRITE,
  input wire [31:0] CLOCK_WDATA,
  // Interrupt control
  input wire [FLAGS-1:0] IRQ_ENABLE_SET,
  input wire [FLAGS-1:0] IRQ_ENABLE_CLEAR,
  input wire [FLAGS-1:0] FLAG_CLEAR,
  // Status
  output reg [31:0] CLOCK_VALUE,
  output reg [FLAGS-1:0] INTERRUPT_FLAGS,
  output reg [FLAGS-1:0] IRQ_ENABLES,
  output reg HOUR_FORMAT,
  output wire COUNTER_CLOCK_TICK,
  output wire [7:0] PERIOD_TICK_N,
  output wire IRQ
);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  wire cnt_tick;
  wire [7:0] per_tick;

  rtc_prescaler u_prescaler (
    .CORE_CLK(CORE_CLK),
    .RESET_N(RESET_N),
    .DIV_SEL(DIV_SEL),
    .SRC_TICK(RTC_SOURCE_CLOCK_TICK && ENABLE),
    .CNT_TICK(cnt_tick),
    .PER_TICK(per_tick)
  );

  assign COUNTER_CLOCK_TICK = cnt_tick;
  assign PERIOD_TICK_N = per_tick;

  // ----------------------------------------------------------------
  // Calendar helpers
  // ----------------------------------------------------------------
  function [4:0] days_in_month;
    input [3:0] mon;
    input [5:0] yr;
    begin
      case (mon)
        4'h2: days_in_month = (yr[1:0] == 2'b00) ? 5'h1D : 5'h1C;
        4'h4, 4'h6, 4'h9, 4'hB: days_in_month = 5'h1E;
        default: days_in_month = 5'h1F;
      endcase
    end
  endfunction

  // Mask select N compares the N lowest fields; 6 and above compare all
  function [31:0] alarm_mask;
    input [2:0 ] sel;
    begin
      case (sel)
        3'h0: alarm_mask = 32'h00000000;
        3'h1: alarm_mask = 32'h0000003F;
        3'h2: alarm_mask = 32'h00000FFF;
        3'h3: alarm_mask = 32'h0001FFFF;
        3'h4: alarm_mask = 32'h003FFFFF;
        3'h5: alarm_mask = 32'h03FFFFFF;
        default: alarm_mask = 32'hFFFFFFFF;
      endcase
    end
  endfunction

  // Next hour with the day carry on top; 12-hour form runs 12, 1..11 with PM on top
  function [5:0] hour_step;
    input [4:0] hr;
    input twelve;
    begin
      if (twelve) begin
        if (hr[3:0] == 4'hB) begin
          hour_step = {hr[`PM_BIT], ~hr[`PM_BIT], 4'hC};
        end else if (hr[3:0] == 4'hC) begin
          hour_step = {1'b0, hr[`PM_BIT], 4'h1};
        end else begin
          hour_step = {1'b0, hr + 5'h01};
        end
      end else if (hr == 5'h17) begin
        hour_step = 6'h20;
      end else begin
        hour_step = {1'b0, hr + 5'h01};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Format switch
  // ----------------------------------------------------------------
  // Hour field in the other form; without it a switch leaves an illegal hour
  function [4:0] hour_convert;
    input [4:0] hr;
    input to_twelve;
    begin
      if (to_twelve) begin
        if (hr == 5'h00) begin
          hour_convert = 5'h0C;
        end else if (hr < 5'h0C) begin
          hour_convert = hr;
        end else if (hr == 5'h0C) begin
          hour_convert = 5'h1C;
        end else begin
          hour_convert = {1'b1, hr[3:0] - 4'hC};
        end
      end else begin
        if (hr[3:0] == 4'hC) begin
          hour_convert = hr[`PM_BIT] ? 5'h0C : 5'h00;
        end else begin
          hour_convert = hr[`PM_BIT] ? ({1'b0, hr[3:0]} + 5'h0C) : {1'b0, hr[3:0]};
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Clock increment
  // ----------------------------------------------------------------
  wire [5:0] sec = CLOCK_VALUE[`MIN_LSB-1:`SEC_LSB];
  wire [5:0] min = CLOCK_VALUE[`HOUR_LSB-1:`MIN_LSB];
  wire [4:0] hour = CLOCK_VALUE[`DAY_LSB-1:`HOUR_LSB];
  wire [4:0] day = CLOCK_VALUE[`MON_LSB-1:`DAY_LSB];
  wire [3:0] mon = CLOCK_VALUE[`YEAR_LSB-1:`MON_LSB];
  wire [5:0] yr = CLOCK_VALUE[31:`YEAR_LSB];

  reg [5:0] sec_next;
  reg [5:0] min_next;
  reg [4:0] hour_next;
  reg [4:0] day_next;
  reg [3:0] mon_next;
  reg [5:0] yr_next;
  reg day_carry;
  reg wrap;

  always @* begin
    sec_next = sec;
    min_next = min;
    hour_next = hour;
    day_next = day;
    mon_next = mon;
    yr_next = yr;
    day_carry = 1'b0;
    wrap = 1'b0;
    if (sec == 6'h3B) begin
      sec_next = 6'h00;
      if (min == 6'h3B) begin
        min_next = 6'h00;
        {day_carry, hour_next} = hour_step(hour, HOUR_FORMAT);
      end else begin
        min_next = min + 6'h01;
      end
    end else begin
      sec_next = sec + 6'h01;
    end
    if (day_carry) begin
      if (day >= days_in_month(mon, yr)) begin
        day_next = `DAY_FIRST;
        if (mon == `MONTH_DEC) begin
          mon_next = `MONTH_FIRST;
          yr_next = yr + 6'h01;
          wrap = (yr == `YEAR_TOP);
        end else begin
          mon_next = mon + 4'h1;
        end
      end else begin
        day_next = day + 5'h01;
      end
    end
  end

  // Zero time in either format: 12-hour midnight is 12 AM
  wire [4:0] hour_zero = HOUR_FORMAT ? 5'h0C : 5'h00;
  wire [31:0] clock_zero = {6'h00, `MONTH_FIRST, `DAY_FIRST, hour_zero, 12'h000};
  wire [31:0] clock_inc = {yr_next, mon_next, day_next, hour_next, min_next, sec_next};

  // ----------------------------------------------------------------
  // Match detection
  // ----------------------------------------------------------------
  wire [31:0] amask = alarm_mask(ALARM_MASK_SELECT);
  wire alarm_hit = ((CLOCK_VALUE ^ ALARM_COMPARE_VALUE) & amask) == 32'h00000000;
  wire cmp_hit = (CLOCK_VALUE == COMPARE_VALUE);
  wire [1:0] hit = {cmp_hit, alarm_hit};

  // ----------------------------------------------------------------
  // Match latching: bit 0 alarm, bit 1 compare
  // ----------------------------------------------------------------
  // Match seen on a count; the flag waits for the next counter tick
  reg [1:0] pend_reg;
  reg [1:0] seen_reg;
  wire [1:0] pend_next;
  wire [1:0] seen_next;
  wire restart = cnt_tick || CLOCK_WRITE;

  genvar m;
  generate
    for (m = 0; m < 2; m = m + 1) begin : g_match
      // Latch a match once per clock value so a held match flags once
      assign pend_next[m] = restart ? 1'b0 :
                            (pend_reg[m] | (ENABLE && hit[m] && !seen_reg[m]));
      assign seen_next[m] = restart ? 1'b0 : (seen_reg[m] | (ENABLE && hit[m]));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Counter events
  // ----------------------------------------------------------------
  reg ovf_event;
  reg alarm_event;
  reg cmp_event;

  always @* begin
    ovf_event = 1'b0;
    alarm_event = 1'b0;
    cmp_event = 1'b0;
    if (cnt_tick) begin
      alarm_event = pend_reg[0];
      cmp_event = pend_reg[1];
      if (pend_reg[0] && CLEAR_ON_ALARM_MATCH) begin
        ovf_event = 1'b1;
      end else begin
        ovf_event = wrap;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter state
  // ----------------------------------------------------------------
  // A clock load wins over a tick in the same cycle
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CLOCK_VALUE <= `CLOCK_RESET;
      HOUR_FORMAT <= 1'b0;
      pend_reg <= 2'b00;
      seen_reg <= 2'b00;
    end else begin
      if (!ENABLE) begin
        HOUR_FORMAT <= HOUR_FORMAT_SELECT;
      end
      if (CLOCK_WRITE) begin
        CLOCK_VALUE <= CLOCK_WDATA;
      end else if (cnt_tick) begin
        if (pend_reg[0] && CLEAR_ON_ALARM_MATCH) begin
          CLOCK_VALUE <= clock_zero;
        end else begin
          CLOCK_VALUE <= clock_inc;
        end
      end else if (!ENABLE && HOUR_FORMAT_SELECT != HOUR_FORMAT) begin
        // Keep the time of day when the hour form is switched
        CLOCK_VALUE[`DAY_LSB-1:`HOUR_LSB] <= hour_convert(hour, HOUR_FORMAT_SELECT);
      end
      pend_reg <= pend_next;
      seen_reg <= seen_next;
    end
  end

  // ----------------------------------------------------------------
  // Flags and enables
  // ----------------------------------------------------------------
  wire [FLAGS-1:0] flag_set = {per_tick, alarm_event, cmp_event, ovf_event};
  wire [FLAGS-1:0] flags_next;
  wire [FLAGS-1:0] enables_next;

  // One next-state term per source, so each register keeps a single writer
  genvar g;
  generate
    for (g = 0; g < FLAGS; g = g + 1) begin : g_flag
      // A new event wins over a clear in the same cycle
      assign flags_next[g] = flag_set[g] ? 1'b1 :
                             (FLAG_CLEAR[g] ? 1'b0 : INTERRUPT_FLAGS[g]);
      assign enables_next[g] = IRQ_ENABLE_SET[g] ? 1'b1 :
                               (IRQ_ENABLE_CLEAR[g] ? 1'b0 : IRQ_ENABLES[g]);
    end
  endgenerate

  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INTERRUPT_FLAGS <= {FLAGS{1'b0}};
      IRQ_ENABLES <= {FLAGS{1'b0}};
    end else begin
      INTERRUPT_FLAGS <= flags_next;
      IRQ_ENABLES <= enables_next;
    end
  end

  // ----------------------------------------------------------------
  // Combined request
  // ----------------------------------------------------------------
  // Level request, falls when flag or enable drops
  assign IRQ = |(INTERRUPT_FLAGS & IRQ_ENABLES);

endmodule
`default_nettype wire

// ==== rtc_calendar_core_chk.sv ====
// Port checker for the calendar core.
// Assumes a bind onto rtc_calendar_core.
`timescale 1ns/1ns
`default_nettype none
module rtc_calendar_core_chk #(
  parameter FLAGS = 11
) (
  // Control
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic ENABLE,
  input wire logic CLEAR_ON_ALARM_MATCH,
  input wire logic [3:0] DIV_SEL,
  input wire logic CLOCK_WRITE,
  input wire logic [FLAGS-1:0] IRQ_ENABLE_SET,
  input wire logic [FLAGS-1:0] IRQ_ENABLE_CLEAR,
  input wire logic [FLAGS-1:0] FLAG_CLEAR,
  // Status
  input wire logic [31:0] CLOCK_VALUE,
  input wire logic [FLAGS-1:0] INTERRUPT_FLAGS,
  input wire logic [FLAGS-1:0] IRQ_ENABLES,
  input wire logic HOUR_FORMAT,
  input wire logic COUNTER_CLOCK_TICK,
  input wire logic [7:0] PERIOD_TICK_N,
  input wire logic IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  a_irq_or_flags: assert property (IRQ == |(INTERRUPT_FLAGS & IRQ_ENABLES))
    else $error("irq not or of enabled flags");
  a_enable_set: assert property (
    |IRQ_ENABLE_SET |=> (IRQ_ENABLES & $past(IRQ_ENABLE_SET)) == $past(IRQ_ENABLE_SET))
    else $error("enable bit not set");
  a_enable_clear: assert property (
    |IRQ_ENABLE_CLEAR |=> (IRQ_ENABLES & $past(IRQ_ENABLE_CLEAR) & ~$past(IRQ_ENABLE_SET)) == 0)
    else $error("enable bit not cleared");
  a_flag_hold: assert property (
    ($past(INTERRUPT_FLAGS) & ~INTERRUPT_FLAGS & ~$past(FLAG_CLEAR)) == 0)
    else $error("flag dropped without clear");
  a_format_locked: assert property (ENABLE |=> $stable(HOUR_FORMAT))
    else $error("format changed while enabled");
  a_idle_no_tick: assert property ((!ENABLE) [*2] |=> !COUNTER_CLOCK_TICK)
    else $error("counter tick while disabled");
  a_period_off: assert property ((DIV_SEL == 4'h0) [*2] |=> PERIOD_TICK_N == 8'h00)
    else $error("period tick with divider off");
  a_alarm_on_tick: assert property (
    $rose(INTERRUPT_FLAGS[2]) |-> $past(COUNTER_CLOCK_TICK))
    else $error("alarm flag without counter tick");
  a_match_clear: assert property (
    $rose(INTERRUPT_FLAGS[2]) && $past(CLEAR_ON_ALARM_MATCH) |-> INTERRUPT_FLAGS[0])
    else $error("rollover flag missing on match");
  a_wrap_start: assert property (
    COUNTER_CLOCK_TICK && ENABLE && !CLOCK_WRITE && !HOUR_FORMAT && !CLEAR_ON_ALARM_MATCH
    && CLOCK_VALUE == 32'hFF3F7EFB |=> CLOCK_VALUE == 32'h00420000 && INTERRUPT_FLAGS[0])
    else $error("calendar wrap wrong");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the calendar core; notes checked by a monitor.
// Assumes the core, prescaler and checker compile ahead of it.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct {int code; logic [31:0] mask; logic [31:0] exp;} note_t;
  note_t q[$];
  logic core_clk = 1'b0, reset_n = 1'b0, enable = 1'b0, hour_sel = 1'b0;
  logic clr_match = 1'b0, src_tick = 1'b0, clk_wr = 1'b0, smp = 1'b0;
  logic [3:0] div_sel = 4'h1;
  logic [2:0] mask_sel = 3'h7;
  logic [31:0] alarm_val = 32'hFFFFFFFF, cmp_val = 32'hFFFFFFFF, wdata = 32'h0, seen;
  logic [10:0] en_set = 11'h0, en_clr = 11'h0, flag_clr = 11'h0;
  wire [31:0] clock_value;
  wire [10:0] flags, enables;
  wire [7:0] per_tick;
  wire hour_fmt, cnt_tick, irq;
  int error_cnt = 0, n_tests = 0, tick_cnt = 0, seed = 32'hF645FFFB;
  always #5 core_clk = ~core_clk;
  rtc_calendar_core #(.FLAGS(11)) dut_u (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .ENABLE(enable), .HOUR_FORMAT_SELECT(hour_sel),
    .CLEAR_ON_ALARM_MATCH(clr_match), .DIV_SEL(div_sel), .RTC_SOURCE_CLOCK_TICK(src_tick),
    .ALARM_COMPARE_VALUE(alarm_val), .ALARM_MASK_SELECT(mask_sel), .COMPARE_VALUE(cmp_val),
    .CLOCK_WRITE(clk_wr), .CLOCK_WDATA(wdata), .IRQ_ENABLE_SET(en_set),
    .IRQ_ENABLE_CLEAR(en_clr), .FLAG_CLEAR(flag_clr), .CLOCK_VALUE(clock_value),
    .INTERRUPT_FLAGS(flags), .IRQ_ENABLES(enables), .HOUR_FORMAT(hour_fmt),
    .COUNTER_CLOCK_TICK(cnt_tick), .PERIOD_TICK_N(per_tick), .IRQ(irq));
  always @(posedge core_clk) if (cnt_tick === 1'b1) tick_cnt <= tick_cnt + 1;
  function automatic logic [31:0] pk(input int y, mo, d, h, mi, s);
    return {y[5:0], mo[3:0], d[4:0], h[4:0], mi[5:0], s[5:0]};
  endfunction
  task automatic chk(input int code, input logic [31:0] got, exp);
    string nm[6] = '{"clock", "flags", "enables", "irq", "format", "ticks"};
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm[code], exp, got);
    end
  endtask
  task automatic test_done;
    repeat (3) @(posedge core_clk);
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Monitor: oldest note against the outputs it names
  always @(posedge core_clk) begin
    if (smp && q.size() > 0) begin
      case (q[0].code)
        0: seen = clock_value;
        1: seen = {21'h0, flags};
        2: seen = {21'h0, enables};
        3: seen = {31'h0, irq};
        4: seen = {31'h0, hour_fmt};
        default: seen = tick_cnt;
      endcase
      chk(q[0].code, seen & q[0].mask, q[0].exp);
      void'(q.pop_front());
    end
  end
  task automatic note(input int code, input logic [31:0] mask, exp);
    @(posedge core_clk);
    q.push_back('{code, mask, exp});
    smp <= 1'b1;
    @(posedge core_clk);
    smp <= 1'b0;
  endtask
  task automatic ctl(input logic [10:0] s, c, f);
    @(posedge core_clk);
    en_set <= s;
    en_clr <= c;
    flag_clr <= f;
    @(posedge core_clk);
    en_set <= 11'h0;
    en_clr <= 11'h0;
    flag_clr <= 11'h0;
  endtask
  task automatic pulse_src(input int n);
    repeat (n) begin
      @(posedge core_clk);
      src_tick <= 1'b1;
      @(posedge core_clk);
      src_tick <= 1'b0;
    end
  endtask
  // Bounded wait; a missing tick ends the run
  task automatic wait_tick;
    for (int i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (cnt_tick === 1'b1) return;
    end
    error_cnt++;
    test_done();
  endtask
  task automatic roll(input logic [31:0] a, b);
    @(posedge core_clk);
    wdata <= a;
    clk_wr <= 1'b1;
    @(posedge core_clk);
    clk_wr <= 1'b0;
    pulse_src(1);
    wait_tick();
    note(0, 32'hFFFFFFFF, b);
  endtask
  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    logic [10:0] e, c, p;
    int d, b;
    p = 11'h0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    note(0, 32'hFFFFFFFF, 32'h00420000);
    note(1, 32'h7FF, 32'h0);
    for (d = 0; d < 4; d++) begin
      e = $random(seed);
      c = $random(seed);
      ctl(e, c, 11'h0);
      p = (p & ~c) | e;
      note(2, 32'h7FF, {21'h0, p});
    end
    ctl(11'h1, 11'h7FE, 11'h0);
    enable <= 1'b1;
    roll(pk(63, 12, 31, 23, 59, 59), 32'h00420000);
    note(1, 32'h1, 32'h1);
    note(3, 32'h1, 32'h1);
    ctl(11'h0, 11'h1, 11'h0);
    note(3, 32'h1, 32'h0);
    ctl(11'h1, 11'h0, 11'h6);
    note(3, 32'h1, 32'h1);
    ctl(11'h0, 11'h0, 11'h1);
    note(1, 32'h1, 32'h0);
    note(3, 32'h1, 32'h0);
    roll(pk(4, 2, 28, 23, 59, 59), pk(4, 2, 29, 0, 0, 0));
    roll(pk(5, 2, 28, 23, 59, 59), pk(5, 3, 1, 0, 0, 0));
    roll(pk(5, 1, 31, 23, 59, 59), pk(5, 2, 1, 0, 0, 0));
    roll(pk(5, 12, 31, 23, 59, 59), pk(6, 1, 1, 0, 0, 0));
    enable <= 1'b0;
    hour_sel <= 1'b1;
    note(4, 32'h1, 32'h1);
    note(0, 32'h1F000, 32'h0C000);
    enable <= 1'b1;
    hour_sel <= 1'b0;
    note(4, 32'h1, 32'h1);
    roll(pk(5, 3, 1, 11, 59, 59), pk(5, 3, 1, 28, 0, 0));
    roll(pk(5, 3, 1, 27, 59, 59), pk(5, 3, 2, 12, 0, 0));
    enable <= 1'b0;
    note(4, 32'h1, 32'h0);
    note(0, 32'h1F000, 32'h0);
    enable <= 1'b1;
    ctl(11'h0, 11'h0, 11'h7FF);
    clr_match <= 1'b1;
    mask_sel <= 3'h1;
    alarm_val <= pk(1, 1, 1, 1, 1, 5);
    cmp_val <= pk(7, 3, 9, 10, 33, 5);
    roll(pk(7, 3, 9, 10, 33, 4), pk(7, 3, 9, 10, 33, 5));
    note(1, 32'h7, 32'h0);
    pulse_src(1);
    wait_tick();
    note(1, 32'h7, 32'h7);
    note(0, 32'h3F, 32'h0);
    clr_match <= 1'b0;
    ctl(11'h0, 11'h0, 11'h7FF);
    div_sel <= 4'h0;
    pulse_src(8);
    note(1, 32'h7F8, 32'h0);
    div_sel <= 4'h1;
    pulse_src(8);
    note(1, 32'h8, 32'h8);
    for (d = 0; d < 6; d++) begin
      div_sel <= d[3:0];
      pulse_src(2);
      repeat (3) @(posedge core_clk);
      b = tick_cnt;
      pulse_src(32);
      repeat (3) @(posedge core_clk);
      note(5, 32'hFFFFFFFF, b + (d < 2 ? 32 : 32 >> (d - 1)));
    end
    test_done();
  end
endmodule
bind rtc_calendar_core rtc_calendar_core_chk #(.FLAGS(FLAGS)) chk_u (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .ENABLE(ENABLE), .DIV_SEL(DIV_SEL),
  .CLEAR_ON_ALARM_MATCH(CLEAR_ON_ALARM_MATCH), .CLOCK_WRITE(CLOCK_WRITE),
  .IRQ_ENABLE_SET(IRQ_ENABLE_SET), .IRQ_ENABLE_CLEAR(IRQ_ENABLE_CLEAR),
  .FLAG_CLEAR(FLAG_CLEAR), .CLOCK_VALUE(CLOCK_VALUE), .INTERRUPT_FLAGS(INTERRUPT_FLAGS),
  .IRQ_ENABLES(IRQ_ENABLES), .HOUR_FORMAT(HOUR_FORMAT), .IRQ(IRQ),
  .COUNTER_CLOCK_TICK(COUNTER_CLOCK_TICK), .PERIOD_TICK_N(PERIOD_TICK_N));
`default_nettype wire
